// *** mmd_decoder.sv ***
// Data-space decoder between the processor core and its memories and I/O registers.
// Assumes a core on the same clock that holds a request until it is taken.
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.svh"
module mmd_decoder #(
  parameter int PC_W         = 14,
  parameter int SRAM_DEPTH   = 4096,
  parameter int EE_DEPTH     = 1024,
  parameter int EE_WRITE_CYC = `MMD_EE_WRITE_TIME_US * 1000 / `MMD_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic             I_MCLK,
  input  wire logic             I_RST_N,
  // Core request and answer
  input  wire logic             I_REQ_VALID,
  input  wire mmd_pkg::mmd_req_s I_REQ,
  output logic                  O_REQ_READY,
  output logic                  O_ACK,
  output mmd_pkg::mmd_rsp_s     O_RSP,
  output logic                  O_STALL,
  // Extended I/O peripheral strobe
  output mmd_pkg::mmd_xio_s     O_XIO,
  input  wire logic [7:0]       I_XIO_RDATA,
  // Stack pointer and program counter
  output logic      [15:0]      O_SP,
  input  wire logic             I_PC_LOAD,
  input  wire logic [PC_W-1:0]  I_PC_TARGET,
  input  wire logic             I_PC_INC,
  output logic      [PC_W-1:0]  O_PC
);
  localparam int SAW = $clog2(SRAM_DEPTH);
  localparam int EAW = $clog2(EE_DEPTH);

  typedef struct packed {
    mmd_pkg::mmd_state_e st;
    mmd_pkg::mmd_req_s   req;
    logic [15:0]         ea;
    logic [7:0]          rdata;
    logic                skip;
    logic                sram_sel;
    logic                oor;
    logic [15:0]         sp;
    logic [7:0]          scratch0;
    logic [7:0]          scratch1;
    logic [7:0]          scratch2;
    logic [1:0]          flags;
    logic [EAW-1:0]      ee_addr;
    logic [7:0]          ee_data;
    logic [1:0]          ee_mode;
    logic                ee_rdy_ie;
    logic                ee_master;
    logic [2:0]          ee_master_cnt;
    logic                ee_load;
    logic [2:0]          stall_cnt;
    logic [PC_W-1:0]     pc;
  } mmd_dec_s;

  mmd_dec_s    r;
  mmd_dec_s    next_r;
  logic [7:0]  rf [32];
  logic        take;
  logic [4:0]  ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] ptr_new;
  logic        ptr_we;
  logic [15:0] ea_take;
  logic [5:0]  io_a;
  logic [7:0]  io_rd;
  logic [7:0]  wd;
  logic [7:0]  wm;
  logic        is_rf;
  logic        is_io;
  logic        is_xio;
  logic        is_sram;
  logic        is_store;
  logic        bit_ok;
  logic        io_we;
  logic        ee_rd_trig;
  logic        ee_wr_trig;
  logic [7:0]  sram_q;
  logic [7:0]  ee_q;
  logic        ee_busy;
  logic        ee_done;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val, input logic [7:0] msk);
    merge = (old & ~msk) | (val & msk);
  endfunction : merge

  function automatic logic [4:0] ptr_base(input mmd_pkg::mmd_ptr_e p);
    case (p)
      mmd_pkg::MMD_PTR_Y: ptr_base = 5'h1C;
      mmd_pkg::MMD_PTR_Z: ptr_base = 5'h1E;
      default:            ptr_base = 5'h1A;
    endcase
  endfunction : ptr_base

  assign O_REQ_READY = (r.st == mmd_pkg::MMD_ST_IDLE) ||
                       (r.st == mmd_pkg::MMD_ST_DONE && r.stall_cnt == 3'h0);
  assign take        = I_REQ_VALID && O_REQ_READY;

  // Effective address and pointer update at the moment a request is taken
  always_comb begin
    ptr_lo  = ptr_base(I_REQ.ptr);
    ptr_val = {rf[ptr_lo + 5'h01], rf[ptr_lo]};
    ptr_new = ptr_val;
    ptr_we  = 1'b0;
    ea_take = 16'h0000;
    case (I_REQ.op)
      mmd_pkg::MMD_OP_LOAD, mmd_pkg::MMD_OP_STORE: begin
        case (I_REQ.am)
          mmd_pkg::MMD_AM_DIRECT: ea_take = I_REQ.addr;
          mmd_pkg::MMD_AM_DISP: begin
            // X has no displacement form; the offset is dropped for it
            ea_take = (I_REQ.ptr == mmd_pkg::MMD_PTR_X) ? ptr_val
                    : ptr_val + (I_REQ.addr & `MMD_DISP_MASK);
          end
          mmd_pkg::MMD_AM_PREDEC: begin
            ea_take = ptr_val - 16'h0001;
            ptr_new = ea_take;
            ptr_we  = 1'b1;
          end
          default: begin
            ea_take = ptr_val;
            ptr_new = ptr_val + 16'h0001;
            ptr_we  = 1'b1;
          end
        endcase
      end
      default: ea_take = {10'h000, I_REQ.addr[5:0]} + `MMD_IO_OFFSET;
    endcase
  end

  // Region decode of the latched address
  always_comb begin
    is_rf    = r.ea < `MMD_RF_END;
    is_io    = !is_rf && r.ea < `MMD_IO_END;
    is_xio   = !is_rf && !is_io && r.ea < `MMD_XIO_END;
    is_sram  = r.ea >= `MMD_XIO_END && r.ea < `MMD_SRAM_END;
    io_a     = r.ea[5:0] - 6'h20;
    is_store = r.req.op == mmd_pkg::MMD_OP_STORE || r.req.op == mmd_pkg::MMD_OP_OUT;
    bit_ok   = io_a < `MMD_BIT_IO_END;
    wd       = r.req.wdata;
    wm       = 8'hFF;
    io_we    = is_store && is_io;
    case (r.req.op)
      mmd_pkg::MMD_OP_SET_BIT: begin
        wd    = 8'hFF;
        wm    = 8'h01 << r.req.bit_sel;
        io_we = bit_ok;
      end
      mmd_pkg::MMD_OP_CLR_BIT: begin
        wd    = 8'h00;
        wm    = 8'h01 << r.req.bit_sel;
        io_we = bit_ok;
      end
      default: ;
    endcase
    if (r.st != mmd_pkg::MMD_ST_ACCESS) begin
      io_we = 1'b0;
    end
  end

  always_comb begin
    case (io_a)
      `MMD_IO_STATUS:     io_rd = {6'h00, r.flags};
      `MMD_IO_SCRATCH0:   io_rd = r.scratch0;
      `MMD_IO_EE_CTRL:    io_rd = {2'h0, r.ee_mode, r.ee_rdy_ie, r.ee_master, ee_busy, 1'b0};
      `MMD_IO_EE_DATA:    io_rd = r.ee_data;
      `MMD_IO_EE_ADDR_LO: io_rd = r.ee_addr[7:0];
      `MMD_IO_EE_ADDR_HI: io_rd = 8'({r.ee_addr[EAW-1:8]});
      `MMD_IO_SCRATCH1:   io_rd = r.scratch1;
      `MMD_IO_SCRATCH2:   io_rd = r.scratch2;
      `MMD_IO_SP_LO:      io_rd = r.sp[7:0];
      `MMD_IO_SP_HI:      io_rd = r.sp[15:8];
      default:            io_rd = `MMD_BYTE_RESET;
    endcase
  end

  // The write trigger needs the master enable still open; both need no program in flight
  assign ee_wr_trig = io_we && io_a == `MMD_IO_EE_CTRL && wm[`MMD_EE_WRITE_BIT] && wd[`MMD_EE_WRITE_BIT]
                      && r.ee_master && !ee_busy;
  assign ee_rd_trig = io_we && io_a == `MMD_IO_EE_CTRL && wm[`MMD_EE_READ_BIT] && wd[`MMD_EE_READ_BIT]
                      && !ee_busy;

  always_comb begin
    next_r = r;
    if (I_PC_LOAD) begin
      next_r.pc = I_PC_TARGET;
    end else if (I_PC_INC) begin
      next_r.pc = r.pc + 1'b1;
    end
    if (r.ee_load) begin
      next_r.ee_data = ee_q;
      next_r.ee_load = 1'b0;
    end
    if (r.ee_master) begin
      next_r.ee_master_cnt = r.ee_master_cnt + 3'h1;
      if (r.ee_master_cnt == `MMD_EE_MASTER_WIN - 3'h1) begin
        next_r.ee_master = 1'b0;
      end
    end
    if (ee_done) begin
      next_r.flags[`MMD_ST_EE_DONE_BIT] = 1'b1;
    end
    case (r.st)
      mmd_pkg::MMD_ST_ACCESS: begin
        next_r.st       = mmd_pkg::MMD_ST_DONE;
        next_r.sram_sel = is_sram;
        next_r.oor      = r.ea >= `MMD_SRAM_END;
        next_r.skip     = 1'b0;
        next_r.rdata    = `MMD_BYTE_RESET;
        if (is_rf) begin
          next_r.rdata = rf[r.ea[4:0]];
        end else if (is_io) begin
          next_r.rdata = io_rd;
          next_r.skip  = bit_ok && (io_rd[r.req.bit_sel] == (r.req.op == mmd_pkg::MMD_OP_SKIP_SET))
                         && (r.req.op == mmd_pkg::MMD_OP_SKIP_SET || r.req.op == mmd_pkg::MMD_OP_SKIP_CLR);
        end else if (is_xio) begin
          next_r.rdata = I_XIO_RDATA;
        end
        if (io_we) begin
          case (io_a)
            // A done event in the same cycle as its clear must not be lost
            `MMD_IO_STATUS:   next_r.flags = (r.flags & ~(wd[1:0] & wm[1:0])) | {1'b0, ee_done};
            `MMD_IO_SCRATCH0: next_r.scratch0 = merge(r.scratch0, wd, wm);
            `MMD_IO_SCRATCH1: next_r.scratch1 = merge(r.scratch1, wd, wm);
            `MMD_IO_SCRATCH2: next_r.scratch2 = merge(r.scratch2, wd, wm);
            `MMD_IO_SP_LO:    next_r.sp[7:0]  = merge(r.sp[7:0], wd, wm);
            `MMD_IO_SP_HI:    next_r.sp[15:8] = merge(r.sp[15:8], wd, wm);
            `MMD_IO_EE_DATA:  next_r.ee_data = merge(r.ee_data, wd, wm);
            `MMD_IO_EE_ADDR_LO: if (!ee_busy) next_r.ee_addr[7:0] = merge(r.ee_addr[7:0], wd, wm);
            `MMD_IO_EE_ADDR_HI: if (!ee_busy) next_r.ee_addr[EAW-1:8] = wd[EAW-9:0];
            `MMD_IO_EE_CTRL: begin
              if (!ee_busy) begin
                next_r.ee_mode = 2'(merge({6'h00, r.ee_mode}, wd >> `MMD_EE_MODE_LSB, wm >> `MMD_EE_MODE_LSB));
              end
              if (wm[`MMD_EE_RDYIE_BIT]) next_r.ee_rdy_ie = wd[`MMD_EE_RDYIE_BIT];
              if (wm[`MMD_EE_MASTER_BIT] && wd[`MMD_EE_MASTER_BIT] && !r.ee_master) begin
                next_r.ee_master     = 1'b1;
                next_r.ee_master_cnt = 3'h0;
              end
            end
            default: ;
          endcase
        end
        if (next_r.oor) begin
          next_r.flags[`MMD_ST_OOR_BIT] = 1'b1;
        end
        if (ee_rd_trig) begin
          next_r.ee_load   = 1'b1;
          next_r.stall_cnt = `MMD_EE_RD_STALL;
        end else if (ee_wr_trig) begin
          next_r.ee_master = 1'b0;
          next_r.stall_cnt = `MMD_EE_WR_STALL;
        end
      end
      mmd_pkg::MMD_ST_STALL: begin
        next_r.stall_cnt = r.stall_cnt - 3'h1;
        if (r.stall_cnt == 3'h1) begin
          next_r.st = mmd_pkg::MMD_ST_IDLE;
        end
      end
      mmd_pkg::MMD_ST_IDLE, mmd_pkg::MMD_ST_DONE: begin
        if (take) begin
          next_r.st  = mmd_pkg::MMD_ST_ACCESS;
          next_r.req = I_REQ;
          next_r.ea  = ea_take;
        end else if (r.st == mmd_pkg::MMD_ST_DONE && r.stall_cnt != 3'h0) begin
          next_r.st = mmd_pkg::MMD_ST_STALL;
        end else begin
          next_r.st = mmd_pkg::MMD_ST_IDLE;
        end
      end
      default: next_r.st = mmd_pkg::MMD_ST_IDLE;
    endcase
  end

  // Reset clears the state machine, so a store not yet in its access cycle never lands
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r    <= '0;
      r.sp <= `MMD_SP_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Working registers carry no reset, like the SRAM
  always_ff @(posedge I_MCLK) begin
    if (take && ptr_we) begin
      rf[ptr_lo]         <= ptr_new[7:0];
      rf[ptr_lo + 5'h01] <= ptr_new[15:8];
    end else if (r.st == mmd_pkg::MMD_ST_ACCESS && is_store && is_rf) begin
      rf[r.ea[4:0]] <= wd;
    end
  end

  mmd_sram #(.DEPTH(SRAM_DEPTH), .AW(SAW)) u_sram (
    .i_clk   (I_MCLK),
    .i_addr  (SAW'(r.ea - `MMD_XIO_END)),
    .i_we    (r.st == mmd_pkg::MMD_ST_ACCESS && is_store && is_sram),
    .i_wdata (wd),
    .o_rdata (sram_q)
  );

  mmd_eeprom #(.DEPTH(EE_DEPTH), .AW(EAW), .WRITE_CYC(EE_WRITE_CYC)) u_eeprom (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_rd    (ee_rd_trig),
    .i_addr  (r.ee_addr),
    .o_rdata (ee_q),
    .i_start (ee_wr_trig),
    .i_mode  (r.ee_mode),
    .i_wdata (r.ee_data),
    .o_busy  (ee_busy),
    .o_done  (ee_done)
  );

  assign O_ACK       = r.st == mmd_pkg::MMD_ST_DONE;
  assign O_RSP.rdata = r.sram_sel ? sram_q : r.rdata;
  assign O_RSP.skip  = r.skip;
  assign O_STALL     = r.st == mmd_pkg::MMD_ST_STALL;
  assign O_SP        = r.sp;
  assign O_PC        = r.pc;
  assign O_XIO.addr  = r.ea[7:0];
  assign O_XIO.wdata = r.req.wdata;
  assign O_XIO.we    = r.st == mmd_pkg::MMD_ST_ACCESS && is_xio && r.req.op == mmd_pkg::MMD_OP_STORE;
  assign O_XIO.re    = r.st == mmd_pkg::MMD_ST_ACCESS && is_xio && r.req.op == mmd_pkg::MMD_OP_LOAD;

  a_access_two_cycles: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    take |=> !O_ACK ##1 O_ACK) else $error("access did not answer in two cycles");
  a_ee_read_stall: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    ee_rd_trig |-> ##2 O_STALL [*4] ##1 !O_STALL) else $error("eeprom read stall not four cycles");
  a_ee_write_stall: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    ee_wr_trig |-> ##2 O_STALL [*2] ##1 !O_STALL) else $error("eeprom write stall not two cycles");
  a_beyond_reads_zero: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    O_ACK && r.oor |-> O_RSP.rdata == 8'h00) else $error("out of range read not zero");
  a_xio_load_store: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    take && !(I_REQ.op inside {mmd_pkg::MMD_OP_LOAD, mmd_pkg::MMD_OP_STORE})
    |=> O_XIO.addr inside {[8'h20 : 8'h5F]}) else $error("extended I/O reached by port instruction");
  a_predec_pointer: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    take && I_REQ.am == mmd_pkg::MMD_AM_PREDEC && I_REQ.op == mmd_pkg::MMD_OP_LOAD
    |=> r.ea == $past(ptr_val) - 16'h0001) else $error("pre-decrement address wrong");
  a_out_sp_offset: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    take && I_REQ.op == mmd_pkg::MMD_OP_OUT && I_REQ.addr[5:0] == `MMD_IO_SP_LO
    |-> ##2 O_SP[7:0] == $past(I_REQ.wdata, 2)) else $error("port write to stack pointer lost");
  a_bit_op_one_bit: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    io_we && io_a == `MMD_IO_SCRATCH0 && r.req.op == mmd_pkg::MMD_OP_SET_BIT
    |=> (r.scratch0 & ~$past(wm)) == ($past(r.scratch0) & ~$past(wm))) else $error("bit op touched other bits");
  a_master_timeout: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    $rose(r.ee_master) && !ee_wr_trig |-> ##4 !r.ee_master) else $error("master enable outlived its window");
  a_flag_set_wins: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    ee_done |=> r.flags[`MMD_ST_EE_DONE_BIT]) else $error("eeprom done flag lost");
endmodule : mmd_decoder
`default_nettype wire

// *** mmd_decoder_tb_top.sv ***
// Self-checking bench for the data-space decoder.
// Assumes the core contract: take on valid and ready, answer two cycles later.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_tb_top;
  logic mclk = 0, rst_n = 0, valid = 0, pc_ld = 0, pc_inc = 0;
  logic [13:0] pc_tgt = '0;
  mmd_pkg::mmd_req_s req = '0;
  mmd_pkg::mmd_rsp_s rsp, last;
  mmd_pkg::mmd_xio_s xio;
  logic ready, ack, stall;
  logic [7:0] xrd;
  logic [15:0] sp;
  logic [13:0] pc;
  int failures = 0, num_checks = 0, lat, stl;
  always #50 mclk = ~mclk;
  mmd_decoder #(.EE_WRITE_CYC(20)) u_dut (.I_MCLK(mclk), .I_RST_N(rst_n), .I_REQ_VALID(valid),
    .I_REQ(req), .O_REQ_READY(ready), .O_ACK(ack), .O_RSP(rsp), .O_STALL(stall), .O_XIO(xio),
    .I_XIO_RDATA(xrd), .O_SP(sp), .I_PC_LOAD(pc_ld), .I_PC_TARGET(pc_tgt), .I_PC_INC(pc_inc), .O_PC(pc));
  mmd_xio_model u_xio (.i_clk(mclk), .i_xio(xio), .o_rdata(xrd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input mmd_pkg::mmd_op_e op, input logic [15:0] a, input logic [7:0] d = 8'h00,
                      input logic [2:0] b = 3'h0, input mmd_pkg::mmd_am_e am = mmd_pkg::MMD_AM_DIRECT);
    @(negedge mclk);
    valid = 1;
    req = '{op, am, mmd_pkg::MMD_PTR_Z, a, d, b};
    while (ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    valid = 0;
    lat = 1;
    while (ack !== 1'b1 && lat < 9) begin
      @(negedge mclk);
      lat++;
    end
    last = rsp;
    stl = 0;
    for (int k = 0; k < 10 && ready !== 1'b1; k++) begin
      @(negedge mclk);
      stl += int'(stall === 1'b1);
    end
    chk(16'(lat), 16'h0002);
  endtask : xfer
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic t_reset_and_sram;
    chk(sp, 16'h0000);
    xfer(mmd_pkg::MMD_OP_STORE, 16'h10FF, 8'h3C);
    xfer(mmd_pkg::MMD_OP_STORE, 16'h1100, 8'h77);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h1100);
    chk(16'(last.rdata), 16'h0000);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h10FF);
    chk(16'(last.rdata), 16'h003C);
  endtask : t_reset_and_sram
  task automatic t_io_and_bits;
    xfer(mmd_pkg::MMD_OP_OUT, 16'h003D, 8'h5A);
    xfer(mmd_pkg::MMD_OP_STORE, 16'h005E, 8'h10);
    chk(sp, 16'h105A);
    xfer(mmd_pkg::MMD_OP_OUT, 16'h001E, 8'h81);
    xfer(mmd_pkg::MMD_OP_SET_BIT, 16'h001E, 8'h00, 3'h3);
    xfer(mmd_pkg::MMD_OP_CLR_BIT, 16'h001E, 8'h00, 3'h0);
    xfer(mmd_pkg::MMD_OP_SKIP_SET, 16'h001E, 8'h00, 3'h3);
    chk(16'(last.skip), 16'h0001);
    xfer(mmd_pkg::MMD_OP_SKIP_CLR, 16'h001E, 8'h00, 3'h7);
    chk(16'(last.skip), 16'h0000);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h003E);
    chk(16'(last.rdata), 16'h0088);
    xfer(mmd_pkg::MMD_OP_STORE, 16'h0080, 8'hC3);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h0080);
    chk(16'(last.rdata), 16'h00C3);
  endtask : t_io_and_bits
  task automatic t_pointer;
    xfer(mmd_pkg::MMD_OP_STORE, 16'h001E, 8'h00);
    xfer(mmd_pkg::MMD_OP_STORE, 16'h001F, 8'h01);
    xfer(mmd_pkg::MMD_OP_STORE, 16'h0000, 8'h11, 3'h0, mmd_pkg::MMD_AM_POSTINC);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h001E);
    chk(16'(last.rdata), 16'h0001);
    xfer(mmd_pkg::MMD_OP_STORE, 16'h0140, 8'h5A);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h003F, 8'h00, 3'h0, mmd_pkg::MMD_AM_DISP);
    chk(16'(last.rdata), 16'h005A);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h0100);
    chk(16'(last.rdata), 16'h0011);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h0000, 8'h00, 3'h0, mmd_pkg::MMD_AM_PREDEC);
    chk(16'(last.rdata), 16'h0011);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h001E);
    chk(16'(last.rdata), 16'h0000);
  endtask : t_pointer
  task automatic t_eeprom;
    xfer(mmd_pkg::MMD_OP_OUT, 16'h001F, 8'h00);
    xfer(mmd_pkg::MMD_OP_OUT, 16'h0021, 8'h05);
    xfer(mmd_pkg::MMD_OP_OUT, 16'h0022, 8'h00);
    xfer(mmd_pkg::MMD_OP_OUT, 16'h0020, 8'hA5);
    // Master enable then write enable inside its window
    xfer(mmd_pkg::MMD_OP_SET_BIT, 16'h001F, 8'h00, 3'h2);
    xfer(mmd_pkg::MMD_OP_SET_BIT, 16'h001F, 8'h00, 3'h1);
    chk(16'(stl), 16'h0002);
    xfer(mmd_pkg::MMD_OP_IN, 16'h001F);
    chk(16'(last.rdata[1]), 16'h0001);
    for (int k = 0; k < 20 && last.rdata[1] !== 1'b0; k++) xfer(mmd_pkg::MMD_OP_IN, 16'h001F);
    xfer(mmd_pkg::MMD_OP_IN, 16'h001C);
    chk(16'(last.rdata[0]), 16'h0001);
    chk(16'(last.rdata[1]), 16'h0001);
    xfer(mmd_pkg::MMD_OP_OUT, 16'h001C, 8'h02);
    xfer(mmd_pkg::MMD_OP_IN, 16'h001C);
    chk(16'(last.rdata), 16'h0001);
    xfer(mmd_pkg::MMD_OP_OUT, 16'h0020, 8'h00);
    xfer(mmd_pkg::MMD_OP_SET_BIT, 16'h001F, 8'h00, 3'h0);
    chk(16'(stl), 16'h0004);
    xfer(mmd_pkg::MMD_OP_IN, 16'h0020);
    chk(16'(last.rdata), 16'h00A5);
    // Master enable left to lapse, so the late write strobe must be refused
    xfer(mmd_pkg::MMD_OP_SET_BIT, 16'h001F, 8'h00, 3'h2);
    repeat (4) @(negedge mclk);
    xfer(mmd_pkg::MMD_OP_SET_BIT, 16'h001F, 8'h00, 3'h1);
    chk(16'(stl), 16'h0000);
    xfer(mmd_pkg::MMD_OP_IN, 16'h001F);
    chk(16'(last.rdata[1]), 16'h0000);
  endtask : t_eeprom
  task automatic t_warm_reset_and_pc;
    @(negedge mclk);
    rst_n = 0;
    @(negedge mclk);
    rst_n = 1;
    chk(sp, 16'h0000);
    xfer(mmd_pkg::MMD_OP_LOAD, 16'h10FF);
    chk(16'(last.rdata), 16'h003C);
    pc_ld = 1;
    pc_tgt = 14'h3FFE;
    @(negedge mclk);
    pc_ld = 0;
    pc_inc = 1;
    @(negedge mclk);
    pc_inc = 0;
    chk(16'(pc), 16'h3FFF);
  endtask : t_warm_reset_and_pc
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1;
    t_reset_and_sram();
    t_io_and_bits();
    t_pointer();
    t_eeprom();
    t_warm_reset_and_pc();
    complete_run();
  end
  // Whole run is under two hundred cycles; this limit only cuts a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    complete_run();
  end
endmodule : mmd_decoder_tb_top
`default_nettype wire

// *** mmd_eeprom.sv ***
// Byte-wide data EEPROM with a self-timed write engine.
// Assumes start and read pulses are never given while busy.
`timescale 1ns/1ps
`default_nettype none
module mmd_eeprom #(
  parameter int DEPTH     = 1024,
  parameter int AW        = 10,
  parameter int WRITE_CYC = 34000
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // Read port
  input  wire logic          i_rd,
  input  wire logic [AW-1:0] i_addr,
  output logic      [7:0]    o_rdata,
  // Write engine
  input  wire logic          i_start,
  input  wire logic [1:0]    i_mode,
  input  wire logic [7:0]    i_wdata,
  output logic               o_busy,
  output logic               o_done
);
  localparam int CW = $clog2(WRITE_CYC + 1);

  typedef struct packed {
    logic          busy;
    logic [CW-1:0] cnt;
    logic [AW-1:0] addr;
    logic [7:0]    data;
    logic [1:0]    mode;
    logic [7:0]    rdata;
    logic          done;
  } mmd_ee_s;

  mmd_ee_s    r;
  mmd_ee_s    next_r;
  logic [7:0] mem [DEPTH];
  logic       commit;
  logic [7:0] commit_val;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    commit = 1'b0;
    if (i_rd) begin
      next_r.rdata = mem[i_addr];
    end
    if (i_start && !r.busy) begin
      next_r = '{busy: 1'b1, cnt: '0, addr: i_addr, data: i_wdata, mode: i_mode,
                 rdata: next_r.rdata, done: 1'b0};
    end else if (r.busy) begin
      next_r.cnt = r.cnt + 1'b1;
      if (r.cnt == CW'(WRITE_CYC - 1)) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        commit = 1'b1;
      end
    end
    case (r.mode)
      `MMD_EE_MODE_ERASE: commit_val = `MMD_EE_ERASED;
      `MMD_EE_MODE_WRITE: commit_val = mem[r.addr] & r.data;
      default:            commit_val = r.data;
    endcase
  end

  // Cell contents change only when the timed program ends; a reset mid-write loses it
  always_ff @(posedge i_clk) begin
    if (commit) begin
      mem[r.addr] <= commit_val;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_busy  = r.busy;
  assign o_done  = r.done;
endmodule : mmd_eeprom
`default_nettype wire

// *** mmd_pkg.sv ***
// Types shared by the memory decoder and the core facing it.
// Assumes a single CPU clock domain.
`default_nettype none
package mmd_pkg;

  typedef enum logic [2:0] {
    MMD_OP_LOAD, MMD_OP_STORE, MMD_OP_IN, MMD_OP_OUT,
    MMD_OP_SET_BIT, MMD_OP_CLR_BIT, MMD_OP_SKIP_SET, MMD_OP_SKIP_CLR
  } mmd_op_e;

  typedef enum logic [1:0] {MMD_AM_DIRECT, MMD_AM_DISP, MMD_AM_PREDEC, MMD_AM_POSTINC} mmd_am_e;

  typedef enum logic [1:0] {MMD_PTR_X, MMD_PTR_Y, MMD_PTR_Z} mmd_ptr_e;

  typedef enum {MMD_ST_IDLE, MMD_ST_ACCESS, MMD_ST_DONE, MMD_ST_STALL} mmd_state_e;

  typedef struct packed {
    mmd_op_e     op;
    mmd_am_e     am;
    mmd_ptr_e    ptr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  bit_sel;
  } mmd_req_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic       skip;
  } mmd_rsp_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } mmd_xio_s;

endpackage : mmd_pkg
`default_nettype wire

// *** mmd_regs.svh ***
// Memory map, field positions, reset values and timing counts of the memory decoder.
// Definitions only; included by the decoder, while the EEPROM uses its mode codes and erased value without including it.
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH

// Linear data space boundaries (exclusive ends)
`define MMD_RF_END          16'h0020
`define MMD_IO_END          16'h0060
`define MMD_XIO_END         16'h0100
`define MMD_SRAM_END        16'h1100
`define MMD_IO_OFFSET       16'h0020
`define MMD_BIT_IO_END      6'h20
`define MMD_DISP_MASK       16'h003F

// I/O addresses (port numbering, add offset for data space)
`define MMD_IO_STATUS       6'h1C
`define MMD_IO_SCRATCH0     6'h1E
`define MMD_IO_EE_CTRL      6'h1F
`define MMD_IO_EE_DATA      6'h20
`define MMD_IO_EE_ADDR_LO   6'h21
`define MMD_IO_EE_ADDR_HI   6'h22
`define MMD_IO_SCRATCH1     6'h2A
`define MMD_IO_SCRATCH2     6'h2B
`define MMD_IO_SP_LO        6'h3D
`define MMD_IO_SP_HI        6'h3E

// EEPROM control fields
`define MMD_EE_READ_BIT     0
`define MMD_EE_WRITE_BIT    1
`define MMD_EE_MASTER_BIT   2
`define MMD_EE_RDYIE_BIT    3
`define MMD_EE_MODE_LSB     4
`define MMD_EE_MODE_ATOMIC  2'h0
`define MMD_EE_MODE_ERASE   2'h1
`define MMD_EE_MODE_WRITE   2'h2
`define MMD_EE_ERASED       8'hFF

// Status flags, write one to clear
`define MMD_ST_EE_DONE_BIT  0
`define MMD_ST_OOR_BIT      1

// Reset values
`define MMD_SP_RESET        16'h0000
`define MMD_BYTE_RESET      8'h00

// Timing
`define MMD_CLK_PERIOD_NS   100
`define MMD_EE_WRITE_TIME_US 3400
`define MMD_EE_RD_STALL     3'h4
`define MMD_EE_WR_STALL     3'h2
`define MMD_EE_MASTER_WIN   3'h4
`define MMD_FLASH_WORDS     16384

`endif

// *** mmd_sram.sv ***
// Internal data SRAM, one byte per word, registered read.
// Has no reset: contents survive every reset; only power-up leaves them undefined.
`timescale 1ns/1ps
`default_nettype none
module mmd_sram #(
  parameter int DEPTH = 4096,
  parameter int AW    = 12
) (
  // Clock
  input  wire logic          i_clk,
  // Access port
  input  wire logic [AW-1:0] i_addr,
  input  wire logic          i_we,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule : mmd_sram
`default_nettype wire

// *** mmd_xio_model.sv ***
// Extended I/O peripheral model facing the decoder strobe.
// Assumes one clock; reads are taken in the strobe cycle.
`timescale 1ns/1ps
`default_nettype none
module mmd_xio_model (
  // Clock and strobe
  input  wire logic              i_clk,
  input  wire mmd_pkg::mmd_xio_s i_xio,
  // Read data
  output logic [7:0]             o_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last;
  always_ff @(posedge i_clk) begin
    if (i_xio.we) mem[i_xio.addr] <= i_xio.wdata;
    last <= o_rdata;
  end
  // Outside a read the bus flips, so stale data can never pass as an answer
  assign o_rdata = i_xio.re ? mem[i_xio.addr] : ~last;
endmodule : mmd_xio_model
`default_nettype wire
